// ===== logic/xpcs_top.sv
// XAUI code mapping: XGMII to 8b/10b transmit, align, deskew and decode receive.
// Assumes PMA code groups arrive as 10-bit words on the core clock, one per lane.
//
// Summary of operation
// - Data bytes with control bit clear encode as ordinary Dxx.y code groups.
// - Idle character 07 encodes as K28.0, K28.3 or K28.5.
// - Start, terminate, error encode as K27.7, K29.7, K30.7.
// - Sequence character 9C encodes as K28.4.
// - Received code groups decode back to 32-bit XGMII data and control.
// - Each lane's code stream leaves as its own 10-bit group on pma_tx_code, one per clock.
// - Code alignment and lane deskew use idle code groups, no upper support.
// - Core clock drives word aligner; there is no rate-match stage.
// - Core clock drives decoder, deskew and the receive FIFO write enable.
// - With byte deserialisation on, receive FIFO write rate is halved.
// - Core clock is an input, not exported; fabric launches and captures with it.
// - Fabric width 8, 10, 16 or 20; PMA width 10 only.
`timescale 1ns/10ps
`default_nettype none
module xpcs_top
    import xpcs_pkg::*;
#(
    parameter int unsigned FAB_W = xpcs_pkg::FAB_W_DEF,
    parameter int unsigned PMA_W = xpcs_pkg::PMA_W_DEF
)(
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    input  wire logic [31:0]             xgmii_txd,
    input  wire logic [3:0]              xgmii_txc,
    input  wire logic [4*PMA_W-1:0]      pma_rx_code,
    input  wire logic                    byte_deser_en,
    output var  logic [4*PMA_W-1:0]      pma_tx_code,
    output var  logic [31:0]             xgmii_rxd,
    output var  logic [3:0]              xgmii_rxc,
    output var  logic [3:0]              rx_code_err,
    output var  logic [3:0]              rx_lane_sync,
    output var  logic                    rx_deskew_lock,
    output var  logic                    rx_fifo_wr_en
);
    import xpcs_pkg::*;

    if (!(FAB_W == 8 || FAB_W == 10 || FAB_W == 16 || FAB_W == 20)) begin : g_bad_fab_w
        $error("fabric width must be 8, 10, 16 or 20");
    end
    if (PMA_W != 10) begin : g_bad_pma_w
        $error("this build serves a 10-bit PMA width only");
    end

    // Decode one 10-bit group: {err, ctrl, byte}
    function automatic logic [9:0] dec10(input logic [9:0] c);
        logic [4:0] x;
        logic [2:0] y;
        logic       k;
        logic       f6;
        logic       f4;
        logic [5:0] t6;
        logic [3:0] t4;
        x  = 5'h00;
        y  = 3'h0;
        f6 = 1'b0;
        f4 = 1'b0;
        t6 = 6'h00;
        t4 = 4'h0;
        k  = (c[9:4] == K28_6B) || (c[9:4] == ~K28_6B);
        // Balanced sub-blocks other than D.07 have one form only
        for (int i = 0; i < 32; i++) begin
            t6 = xpcs_tbl6(5'(i));
            if (!f6 && (c[9:4] == t6 ||
                        (c[9:4] == ~t6 && (xpcs_unbal6(t6) || 5'(i) == 5'h07)))) begin
                x  = 5'(i);
                f6 = 1'b1;
            end
        end
        if (k) begin
            x  = X_K28;
            f6 = 1'b1;
        end
        if ((c[3:0] == A7_4B) || (c[3:0] == ~A7_4B)) begin
            y  = Y_SEVEN;
            f4 = 1'b1;
            k  = k || (x == 5'h17) || (x == 5'h1b) || (x == 5'h1d) || (x == 5'h1e);
        end
        for (int j = 0; j < 8; j++) begin
            t4 = xpcs_tbl4(3'(j), k);
            if (!f4 && (k ? (c[3:0] == ((c[9:4] == K28_6B) ? ~t4 : t4)) :
                        (c[3:0] == t4 || (c[3:0] == ~t4 &&
                         ($countones(t4) != 2 || 3'(j) == Y_THREE))))) begin
                y  = 3'(j);
                f4 = 1'b1;
            end
        end
        return {!(f6 && f4), k, y, x};
    endfunction : dec10

    // Code group to XGMII character: {ctrl, byte}
    function automatic logic [8:0] to_xgmii(input logic [9:0] d);
        logic [8:0] r;
        if (d[9]) begin
            r = {1'b1, XG_ERR};
        end else if (!d[8]) begin
            r = {1'b0, d[7:0]};
        end else begin
            case (d[7:0])
                K28_0, K28_3, K28_5: r = {1'b1, XG_IDLE};
                K28_4:               r = {1'b1, XG_SEQ};
                K27_7:               r = {1'b1, XG_START};
                K29_7:               r = {1'b1, XG_TERM};
                default:             r = {1'b1, XG_ERR};
            endcase
        end
        return r;
    endfunction : to_xgmii

    // ---------------- Transmit ----------------
    logic [6:0] prbs_r;
    logic [6:0] prbs_nxt;
    logic [4:0] a_cnt_r;
    logic [4:0] a_cnt_nxt;
    logic [7:0] tx_byte [LANES];
    logic [3:0] tx_ctrl;
    xpcs_col_e  col_sel;

    always_comb begin
        logic all_idle;
        all_idle = 1'b1;
        for (int l = 0; l < LANES; l++) begin
            if (!xgmii_txc[l] || xgmii_txd[8*l +: 8] != XG_IDLE) begin
                all_idle = 1'b0;
            end
        end
        prbs_nxt  = {prbs_r[5:0], prbs_r[6] ^ prbs_r[5]};
        a_cnt_nxt = (a_cnt_r != 5'h00) ? a_cnt_r - 5'h01 : 5'h00;
        if (!all_idle) begin
            col_sel = XPCS_COL_K;
        end else if (a_cnt_r == 5'h00) begin
            col_sel   = XPCS_COL_A;
            a_cnt_nxt = A_GAP_MIN + {1'b0, prbs_r[3:0]};
        end else begin
            col_sel = prbs_r[0] ? XPCS_COL_K : XPCS_COL_R;
        end
        for (int l = 0; l < LANES; l++) begin
            tx_ctrl[l] = xgmii_txc[l];
            if (!xgmii_txc[l]) begin
                tx_byte[l] = xgmii_txd[8*l +: 8];
            end else begin
                case (xgmii_txd[8*l +: 8])
                    XG_IDLE: begin
                        case (col_sel)
                            XPCS_COL_A: tx_byte[l] = K28_3;
                            XPCS_COL_R: tx_byte[l] = K28_0;
                            default:    tx_byte[l] = K28_5;
                        endcase
                    end
                    XG_SEQ:   tx_byte[l] = K28_4;
                    XG_START: tx_byte[l] = K27_7;
                    XG_TERM:  tx_byte[l] = K29_7;
                    default:  tx_byte[l] = K30_7;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prbs_r  <= PRBS_SEED;
            a_cnt_r <= A_GAP_MIN;
        end else begin
            prbs_r  <= prbs_nxt;
            a_cnt_r <= a_cnt_nxt;
        end
    end

    for (genvar g = 0; g < LANES; g++) begin : g_enc
        xpcs_lane_enc u_enc (
            .core_clk (core_clk),
            .reset_n  (reset_n),
            .byte_in  (tx_byte[g]),
            .ctrl_in  (tx_ctrl[g]),
            .code_out (pma_tx_code[PMA_W*g +: PMA_W])
        );
    end

    // ---------------- Receive: comma alignment ----------------
    logic [9:0] prev_r  [LANES];
    logic [9:0] prev_nxt[LANES];
    logic [3:0] off_r   [LANES];
    logic [3:0] off_nxt [LANES];
    logic [3:0] sync_r;
    logic [3:0] sync_nxt;
    logic [9:0] alg_r   [LANES];
    logic [9:0] alg_nxt [LANES];

    always_comb begin
        logic [19:0] win;
        win = 20'h00000;
        for (int l = 0; l < LANES; l++) begin
            win         = {prev_r[l], pma_rx_code[PMA_W*l +: PMA_W]};
            prev_nxt[l] = pma_rx_code[PMA_W*l +: PMA_W];
            off_nxt[l]  = off_r[l];
            sync_nxt[l] = sync_r[l];
            for (int o = 0; o < 10; o++) begin
                if (win[19-o -: 7] == COMMA_P || win[19-o -: 7] == ~COMMA_P) begin
                    off_nxt[l]  = 4'(o);
                    sync_nxt[l] = 1'b1;
                end
            end
            alg_nxt[l] = win[19-off_r[l] -: 10];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int l = 0; l < LANES; l++) begin
                prev_r[l] <= 10'h000;
                off_r[l]  <= 4'h0;
                alg_r[l]  <= 10'h000;
            end
            sync_r <= 4'h0;
        end else begin
            for (int l = 0; l < LANES; l++) begin
                prev_r[l] <= prev_nxt[l];
                off_r[l]  <= off_nxt[l];
                alg_r[l]  <= alg_nxt[l];
            end
            sync_r <= sync_nxt;
        end
    end

    // ---------------- Receive: decode, deskew on ||A|| ----------------
    logic [9:0] dly_r   [LANES][DSK_DEPTH];
    logic [9:0] dly_nxt [LANES][DSK_DEPTH];
    logic [2:0] age_r   [LANES];
    logic [2:0] age_nxt [LANES];
    logic [2:0] tap_r   [LANES];
    logic [2:0] tap_nxt [LANES];
    logic [3:0] seen_r;
    logic [3:0] seen_nxt;
    logic       lock_r;
    logic       lock_nxt;
    logic [31:0] rxd_nxt;
    logic [3:0]  rxc_nxt;
    logic [3:0]  err_nxt;
    logic        half_r;
    logic        half_nxt;

    always_comb begin
        logic [9:0] d;
        logic [8:0] xg;
        logic [3:0] s;
        d        = 10'h000;
        xg       = 9'h000;
        lock_nxt = lock_r;
        s        = seen_r;
        for (int l = 0; l < LANES; l++) begin
            d             = dec10(alg_r[l]);
            dly_nxt[l][0] = d;
            for (int t = 1; t < DSK_DEPTH; t++) begin
                dly_nxt[l][t] = dly_r[l][t-1];
            end
            age_nxt[l] = (age_r[l] != 3'h7) ? age_r[l] + 3'h1 : age_r[l];
            tap_nxt[l] = tap_r[l];
            if (d[9:8] == 2'b01 && d[7:0] == K28_3) begin
                s[l]       = 1'b1;
                age_nxt[l] = 3'h0;
            end
        end
        seen_nxt = s;
        if (&s) begin
            for (int l = 0; l < LANES; l++) begin
                tap_nxt[l] = age_nxt[l];
            end
            seen_nxt = 4'h0;
            lock_nxt = 1'b1;
        end else if (seen_r != 4'h0 && s == seen_r && age_nxt[0] == 3'h7 &&
                     age_nxt[1] == 3'h7 && age_nxt[2] == 3'h7 && age_nxt[3] == 3'h7) begin
            seen_nxt = 4'h0;
            lock_nxt = 1'b0;
        end
        for (int l = 0; l < LANES; l++) begin
            xg                 = to_xgmii(dly_r[l][tap_r[l]]);
            rxd_nxt[8*l +: 8]  = xg[7:0];
            rxc_nxt[l]         = xg[8];
            err_nxt[l]         = dly_r[l][tap_r[l]][9];
        end
        half_nxt = byte_deser_en ? ~half_r : 1'b1;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int l = 0; l < LANES; l++) begin
                for (int t = 0; t < DSK_DEPTH; t++) begin
                    dly_r[l][t] <= 10'h000;
                end
                age_r[l] <= 3'h7;
                tap_r[l] <= 3'h0;
            end
            seen_r    <= 4'h0;
            lock_r    <= 1'b0;
            xgmii_rxd <= 32'h0707_0707;
            xgmii_rxc <= 4'hf;
            rx_code_err <= 4'h0;
            half_r    <= 1'b0;
        end else begin
            for (int l = 0; l < LANES; l++) begin
                dly_r[l] <= dly_nxt[l];
                age_r[l] <= age_nxt[l];
                tap_r[l] <= tap_nxt[l];
            end
            seen_r    <= seen_nxt;
            lock_r    <= lock_nxt;
            xgmii_rxd <= rxd_nxt;
            xgmii_rxc <= rxc_nxt;
            rx_code_err <= err_nxt;
            half_r    <= half_nxt;
        end
    end

    assign rx_lane_sync   = sync_r;
    assign rx_deskew_lock = lock_r;
    assign rx_fifo_wr_en  = half_r;

endmodule : xpcs_top
`default_nettype wire

// ===== logic/xpcs_pkg.sv
// Shared constants and 8b/10b code tables for the XAUI code mapping block.
// Assumes a four-lane 10-bit code group interface clocked by one core clock.
package xpcs_pkg;

    localparam int unsigned LANES      = 4;
    localparam int unsigned FAB_W_DEF  = 8;
    localparam int unsigned PMA_W_DEF  = 10;
    localparam int unsigned DSK_DEPTH  = 8;

    // XGMII control characters
    localparam logic [7:0] XG_IDLE  = 8'h07;
    localparam logic [7:0] XG_SEQ   = 8'h9c;
    localparam logic [7:0] XG_START = 8'hfb;
    localparam logic [7:0] XG_TERM  = 8'hfd;
    localparam logic [7:0] XG_ERR   = 8'hfe;

    // Special code groups, byte value HGFEDCBA
    localparam logic [7:0] K28_0 = 8'h1c;
    localparam logic [7:0] K28_3 = 8'h7c;
    localparam logic [7:0] K28_4 = 8'h9c;
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] K27_7 = 8'hfb;
    localparam logic [7:0] K29_7 = 8'hfd;
    localparam logic [7:0] K30_7 = 8'hfe;

    localparam logic [4:0] X_K28   = 5'h1c;
    localparam logic [5:0] K28_6B  = 6'h0f;
    localparam logic [3:0] A7_4B   = 4'h7;
    localparam logic [2:0] Y_SEVEN = 3'h7;
    localparam logic [2:0] Y_THREE = 3'h3;
    localparam logic [6:0] COMMA_P = 7'h1f;

    // Idle randomisation: ||A|| spacing base and scrambler seed
    localparam logic [4:0] A_GAP_MIN = 5'h10;
    localparam logic [6:0] PRBS_SEED = 7'h7f;

    typedef enum logic [1:0] {XPCS_COL_R, XPCS_COL_K, XPCS_COL_A} xpcs_col_e;

    // 5b/6b, negative disparity form, bits abcdei with a as MSB
    function automatic logic [5:0] xpcs_tbl6(input logic [4:0] x);
        logic [5:0] t;
        case (x)
            5'h00: t = 6'h27; 5'h01: t = 6'h1d; 5'h02: t = 6'h2d; 5'h03: t = 6'h31;
            5'h04: t = 6'h35; 5'h05: t = 6'h29; 5'h06: t = 6'h19; 5'h07: t = 6'h38;
            5'h08: t = 6'h39; 5'h09: t = 6'h25; 5'h0a: t = 6'h15; 5'h0b: t = 6'h34;
            5'h0c: t = 6'h0d; 5'h0d: t = 6'h2c; 5'h0e: t = 6'h1c; 5'h0f: t = 6'h17;
            5'h10: t = 6'h1b; 5'h11: t = 6'h23; 5'h12: t = 6'h13; 5'h13: t = 6'h32;
            5'h14: t = 6'h0b; 5'h15: t = 6'h2a; 5'h16: t = 6'h1a; 5'h17: t = 6'h3a;
            5'h18: t = 6'h33; 5'h19: t = 6'h26; 5'h1a: t = 6'h16; 5'h1b: t = 6'h36;
            5'h1c: t = 6'h0e; 5'h1d: t = 6'h2e; 5'h1e: t = 6'h1e; default: t = 6'h2b;
        endcase
        return t;
    endfunction : xpcs_tbl6

    // 3b/4b for negative disparity, data or control table
    function automatic logic [3:0] xpcs_tbl4(input logic [2:0] y, input logic k);
        logic [3:0] t;
        case (y)
            3'h0: t = 4'hb;
            3'h1: t = k ? 4'h6 : 4'h9;
            3'h2: t = k ? 4'ha : 4'h5;
            3'h3: t = 4'hc;
            3'h4: t = 4'hd;
            3'h5: t = k ? 4'h5 : 4'ha;
            3'h6: t = k ? 4'h9 : 4'h6;
            default: t = k ? 4'h7 : 4'he;
        endcase
        return t;
    endfunction : xpcs_tbl4

    function automatic logic xpcs_unbal6(input logic [5:0] v);
        return ($countones(v) != 3);
    endfunction : xpcs_unbal6

endpackage : xpcs_pkg

// ===== logic/xpcs_lane_enc.sv
// One lane 8b/10b encoder with running disparity, registered output.
// Assumes the caller presents one byte and its control flag per clock.
`timescale 1ns/10ps
`default_nettype none
module xpcs_lane_enc
    import xpcs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] byte_in,
    input  wire logic       ctrl_in,
    output var  logic [9:0] code_out
);
    import xpcs_pkg::*;

    logic       rd_r;
    logic       rd_nxt;
    logic [9:0] code_r;
    logic [9:0] code_nxt;

    always_comb begin
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] s6;
        logic [3:0] s4;
        logic       rd6;
        logic       alt;
        x   = byte_in[4:0];
        y   = byte_in[7:5];
        s6  = ctrl_in && (x == X_K28) ? K28_6B : xpcs_tbl6(x);
        // Negative form complemented under positive disparity
        if (rd_r && (xpcs_unbal6(s6) || (x == 5'h07 && !ctrl_in))) begin
            s6 = ~s6;
        end
        rd6 = xpcs_unbal6(s6) ? ~rd_r : rd_r;
        alt = !ctrl_in && (y == Y_SEVEN) &&
              ((!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
               (rd6 && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
        s4  = alt ? A7_4B : xpcs_tbl4(y, ctrl_in);
        if (rd6 && (ctrl_in || alt || ($countones(s4) != 2) || (y == Y_THREE))) begin
            s4 = ~s4;
        end
        rd_nxt   = ($countones(s4) != 2) ? ~rd6 : rd6;
        code_nxt = {s6, s4};
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_r   <= 1'b0;
            code_r <= 10'h000;
        end else begin
            rd_r   <= rd_nxt;
            code_r <= code_nxt;
        end
    end

    assign code_out = code_r;

endmodule : xpcs_lane_enc
`default_nettype wire

// ===== verif/xpcs_top_assertions.sv
// Checker for the XAUI code mapping block, watching top level ports only.
// Assumes one core clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module xpcs_top_assertions
    import xpcs_pkg::*;
#(
    parameter int unsigned PMA_W = 10
)(
    input wire logic               core_clk,
    input wire logic               reset_n,
    input wire logic [31:0]        xgmii_txd,
    input wire logic [3:0]         xgmii_txc,
    input wire logic [4*PMA_W-1:0] pma_rx_code,
    input wire logic               byte_deser_en,
    input wire logic [4*PMA_W-1:0] pma_tx_code,
    input wire logic [31:0]        xgmii_rxd,
    input wire logic [3:0]         xgmii_rxc,
    input wire logic [3:0]         rx_code_err,
    input wire logic [3:0]         rx_lane_sync,
    input wire logic               rx_deskew_lock,
    input wire logic               rx_fifo_wr_en
);
    logic [1:0] up_r;
    logic [1:0] up_nxt;
    logic       up;

    // Cycles since reset release, saturating
    always_comb begin
        up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            up_r <= 2'h0;
        end else begin
            up_r <= up_nxt;
        end
    end
    assign up = (up_r == 2'h3);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_data_not_k: assert property (up && !xgmii_txc[0] |=>
        pma_tx_code[9:4] != 6'h0f && pma_tx_code[9:4] != 6'h30)
        else $error("data byte encoded as K28 group");
    a_idle_codes: assert property (up && xgmii_txc == 4'hf && xgmii_txd == 32'h07070707 |=>
        pma_tx_code[9:0] inside {10'h0f4, 10'h0f3, 10'h0fa, 10'h30b, 10'h30c, 10'h305})
        else $error("idle column not encoded as idle group");
    a_start_code: assert property (up && xgmii_txc[1] && xgmii_txd[15:8] == 8'hfb |=>
        pma_tx_code[19:10] inside {10'h368, 10'h097})
        else $error("start not encoded as K27.7");
    a_term_code: assert property (up && xgmii_txc[2] && xgmii_txd[23:16] == 8'hfd |=>
        pma_tx_code[29:20] inside {10'h2e8, 10'h117})
        else $error("terminate not encoded as K29.7");
    a_seq_code: assert property (up && xgmii_txc[3] && xgmii_txd[31:24] == 8'h9c |=>
        pma_tx_code[39:30] inside {10'h0f2, 10'h30d})
        else $error("sequence not encoded as K28.4");
    a_err_marks_fe: assert property (up && rx_code_err[1] |->
        xgmii_rxc[1] && xgmii_rxd[15:8] == 8'hfe)
        else $error("invalid group not shown as error character");
    a_sync_sticky: assert property (up |->
        (rx_lane_sync & $past(rx_lane_sync)) == $past(rx_lane_sync))
        else $error("lane sync dropped");
    a_comma_sync: assert property (up && pma_rx_code[9:0] inside {10'h0fa, 10'h305} |->
        ##[1:2] rx_lane_sync[0])
        else $error("comma did not set lane sync");
    a_wr_full_rate: assert property (up && !$past(byte_deser_en) && !$past(byte_deser_en, 2) |->
        rx_fifo_wr_en)
        else $error("write enable not constant at full rate");
    a_wr_half_rate: assert property (up && $past(byte_deser_en) && $past(byte_deser_en, 2) |->
        rx_fifo_wr_en != $past(rx_fifo_wr_en))
        else $error("write enable not toggling at half rate");
endmodule : xpcs_top_assertions
`default_nettype wire

// ===== verif/xpcs_remote_model.sv
// Remote transceiver model: echoes each lane's code groups back, one cycle late.
// Assumes the shared core clock; can corrupt chosen lanes with an invalid group.
`timescale 1ns/10ps
`default_nettype none
module xpcs_remote_model (
    input wire logic        core_clk,
    input wire logic [39:0] tx_code,
    input wire logic [3:0]  corrupt,
    output var logic [39:0] rx_code
);
    initial rx_code = 40'h0;

    // Each lane kept in its own 10-bit field, launched on the shared core clock
    // Invalid group has no run over three, so no false comma with neighbours
    always @(posedge core_clk) begin
        for (int l = 0; l < 4; l++) begin
            rx_code[10*l +: 10] <= corrupt[l] ? 10'h375 : tx_code[10*l +: 10];
        end
    end
endmodule : xpcs_remote_model
`default_nettype wire

// ===== verif/tb_xpcs_top.sv
// Self-checking bench for the XAUI code mapping block in loopback.
// Assumes the remote model echoes transmit groups into the receive port.
`timescale 1ns/10ps
`default_nettype none
module tb_xpcs_top;
    import xpcs_pkg::*;
    logic        core_clk;
    logic        reset_n;
    logic [31:0] xgmii_txd;
    logic [3:0]  xgmii_txc;
    logic [39:0] pma_rx_code;
    logic        byte_deser_en;
    logic [39:0] pma_tx_code;
    logic [31:0] xgmii_rxd;
    logic [3:0]  xgmii_rxc;
    logic [3:0]  rx_code_err;
    logic [3:0]  rx_lane_sync;
    logic        rx_deskew_lock;
    logic        rx_fifo_wr_en;
    logic [3:0]  corrupt;
    int          n_errors;
    int          comparisons;

    xpcs_top #(.FAB_W(8), .PMA_W(10)) dut (.core_clk(core_clk), .reset_n(reset_n),
        .xgmii_txd(xgmii_txd), .xgmii_txc(xgmii_txc), .pma_rx_code(pma_rx_code),
        .byte_deser_en(byte_deser_en), .pma_tx_code(pma_tx_code), .xgmii_rxd(xgmii_rxd),
        .xgmii_rxc(xgmii_rxc), .rx_code_err(rx_code_err), .rx_lane_sync(rx_lane_sync),
        .rx_deskew_lock(rx_deskew_lock), .rx_fifo_wr_en(rx_fifo_wr_en));
    xpcs_remote_model partner (.core_clk(core_clk), .tx_code(pma_tx_code),
        .corrupt(corrupt), .rx_code(pma_rx_code));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Picks the disparity form that matches the observed group
    function automatic logic [9:0] pol(input logic [9:0] got, input logic [9:0] neg);
        return (got === ~neg) ? ~neg : neg;
    endfunction : pol

    task automatic col(input logic [31:0] d, input logic [3:0] c);
        @(posedge core_clk);
        #1;
        xgmii_txd = d;
        xgmii_txc = c;
        @(posedge core_clk);
        #1;
    endtask : col

    task automatic lanes(input logic [39:0] neg);
        for (int l = 0; l < 4; l++) begin
            chk(pma_tx_code[10*l +: 10], pol(pma_tx_code[10*l +: 10], neg[10*l +: 10]));
        end
    endtask : lanes

    task automatic t_reset;
        #1;
        chk({pma_tx_code[31:0], 8'h0}, 40'h0);
        chk({xgmii_rxd, xgmii_rxc, rx_code_err}, {32'h07070707, 4'hf, 4'h0});
        chk({rx_lane_sync, rx_deskew_lock, rx_fifo_wr_en}, 6'h00);
    endtask : t_reset

    task automatic t_idle;
        int          a_seen;
        logic [9:0]  g;
        a_seen = 0;
        repeat (48) begin
            @(posedge core_clk);
            #1;
            g = pma_tx_code[9:0];
            a_seen += (g === 10'h0f3 || g === 10'h30c);
            chk(pma_tx_code, {4{g}});
            chk(g, (g === pol(g, 10'h0f4) || g === pol(g, 10'h0f3)) ? g : pol(g, 10'h0fa));
        end
        chk(40'(a_seen > 0), 40'h1);
        chk({rx_lane_sync, rx_deskew_lock}, 5'h1f);
        chk({xgmii_rxd, xgmii_rxc}, {32'h07070707, 4'hf});
    endtask : t_idle

    task automatic t_ctrl;
        logic [7:0] ch [5];
        logic [9:0] kc [5];
        ch = '{8'hfb, 8'hfd, 8'hfe, 8'h9c, 8'h55};
        kc = '{10'h368, 10'h2e8, 10'h1e8, 10'h0f2, 10'h1e8};
        for (int r = 0; r < 5; r++) begin
            col({ch[(r+3)%5], ch[(r+2)%5], ch[(r+1)%5], ch[r]}, 4'hf);
            lanes({kc[(r+3)%5], kc[(r+2)%5], kc[(r+1)%5], kc[r]});
        end
    endtask : t_ctrl

    task automatic t_data;
        col(32'h00ff00ff, 4'h0);
        lanes({10'h274, 10'h2b1, 10'h274, 10'h2b1});
        col(32'hff070007, 4'h5);
        lanes({10'h2b1, 10'h0fa, 10'h274, 10'h0fa});
    endtask : t_data

    task automatic t_rx;
        logic hit;
        col(32'ha55a00ff, 4'h0);
        xgmii_txd = 32'h07070707;
        xgmii_txc = 4'hf;
        hit = 1'b0;
        repeat (20) begin
            @(posedge core_clk);
            #1;
            hit |= (xgmii_rxd === 32'ha55a00ff && xgmii_rxc === 4'h0);
        end
        chk(40'(hit), 40'h1);
    endtask : t_rx

    task automatic t_err;
        logic hit;
        @(posedge core_clk);
        #1;
        corrupt = 4'h2;
        @(posedge core_clk);
        #1;
        corrupt = 4'h0;
        hit = 1'b0;
        repeat (20) begin
            @(posedge core_clk);
            #1;
            hit |= (rx_code_err === 4'h2 && xgmii_rxd[15:8] === 8'hfe && xgmii_rxc[1] === 1'b1);
        end
        chk(40'(hit), 40'h1);
    endtask : t_err

    task automatic t_deser;
        logic prev;
        @(posedge core_clk);
        #1;
        byte_deser_en = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        prev = rx_fifo_wr_en;
        repeat (6) begin
            @(posedge core_clk);
            #1;
            chk(rx_fifo_wr_en, {39'h0, ~prev});
            prev = rx_fifo_wr_en;
        end
        byte_deser_en = 1'b0;
        repeat (2) @(posedge core_clk);
        repeat (4) begin
            @(posedge core_clk);
            #1;
            chk(rx_fifo_wr_en, 1'b1);
        end
    endtask : t_deser

    task automatic summarize;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #8000;
        n_errors++;
        summarize;
    end

    initial begin
        n_errors = 0;
        comparisons = 0;
        reset_n = 1'b0;
        xgmii_txd = 32'h07070707;
        xgmii_txc = 4'hf;
        byte_deser_en = 1'b0;
        corrupt = 4'h0;
        repeat (5) @(posedge core_clk);
        t_reset;
        reset_n = 1'b1;
        t_idle;
        t_ctrl;
        t_data;
        t_rx;
        t_err;
        t_deser;
        @(posedge core_clk);
        #1;
        reset_n = 1'b0;
        t_reset;
        @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge core_clk);
        summarize;
    end
endmodule : tb_xpcs_top

bind xpcs_top xpcs_top_assertions #(.PMA_W(PMA_W)) u_chk (.core_clk(core_clk),
    .reset_n(reset_n), .xgmii_txd(xgmii_txd), .xgmii_txc(xgmii_txc),
    .pma_rx_code(pma_rx_code), .byte_deser_en(byte_deser_en), .pma_tx_code(pma_tx_code),
    .xgmii_rxd(xgmii_rxd), .xgmii_rxc(xgmii_rxc), .rx_code_err(rx_code_err),
    .rx_lane_sync(rx_lane_sync), .rx_deskew_lock(rx_deskew_lock),
    .rx_fifo_wr_en(rx_fifo_wr_en));
`default_nettype wire
